// File: include/tmh_pkg.sv
package tmh_pkg;
  // register addresses on the host bus
  localparam logic [2:0] ADDR_CMD = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_MODE = 3'h2;
  localparam logic [2:0] ADDR_DISC = 3'h3;
  localparam logic [2:0] ADDR_TDIBUF = 3'h4;
  // mode register fields
  localparam int MODE_PIN_DRIVE_BIT = 0;
  localparam int MODE_FREE_RUN_BIT = 1;
  localparam int MODE_DIV_LSB = 4;
  localparam int DIV_W = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // pin-drive register fields
  localparam int DISC_TMS_BIT = 0;
  localparam int DISC_TDO_BIT = 1;
  localparam int DISC_TRST_BIT = 2;
  localparam int DISC_TDI_BIT = 3;
  localparam int DISC_TCK_BIT = 4;
  localparam logic [2:0] DISC_RESET = 3'h4;
  // status register fields
  localparam int STAT_CMD_FULL_BIT = 0;
  localparam int STAT_RST_BUSY_BIT = 1;
  localparam int STAT_TDI_READY_BIT = 7;
  // test-clock periods of the command register internal reset
  localparam logic [1:0] CMD_RESET_TCKS = 2'h3;

  typedef struct packed {
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tmh_req_t;
endpackage

// File: rtl/tmh_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module tmh_host_port (
  // core clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // host link clock domain
  input wire logic hostClock,
  // host bus pins
  input wire logic accessStrobeN,
  input wire logic hostRead,
  input wire logic [2:0] hostAddr,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic ready,
  // command register toward the scan engine
  output logic [7:0] cmdWord,
  output logic cmdValid,
  input wire logic cmdTake,
  // scan-in bytes from the scan engine
  input wire logic [7:0] scanByte,
  input wire logic scanInBufferReadyFlag,
  output logic scanByteTake,
  // gated test clock request from the scan engine
  input wire logic tckGate,
  // test access port pins
  input wire logic tdi,
  output logic tck,
  output logic tms,
  output logic tdo,
  output logic trst
);
  // ==========================================================
  // host domain: strobe capture and ready
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_HOLD} tmh_hstate_t;
  tmh_hstate_t hState_r, hState_nxt;
  logic [1:0] strbS_r, strbS_nxt;
  logic [11:0] busS1_r, busS1_nxt, busS2_r, busS2_nxt;
  tmh_pkg::tmh_req_t req_r, req_nxt;
  logic reqTog_r, reqTog_nxt;
  logic [1:0] ackS_r, ackS_nxt;
  logic [7:0] hData_r, hData_nxt;
  logic ackTog_r;
  logic [7:0] rdata_r;

  always_comb begin
    strbS_nxt = {strbS_r[0], accessStrobeN};
    busS1_nxt = {hostRead, hostAddr, dataIn};
    busS2_nxt = busS1_r;
    ackS_nxt = {ackS_r[0], ackTog_r};
    hState_nxt = hState_r;
    req_nxt = req_r;
    reqTog_nxt = reqTog_r;
    hData_nxt = hData_r;
    case (hState_r)
      H_IDLE: begin
        if (!strbS_r[1]) begin
          req_nxt = busS2_r;
          reqTog_nxt = ~reqTog_r;
          hState_nxt = H_WAIT;
        end
      end
      H_WAIT: begin
        if (ackS_r[1] == reqTog_r) begin
          hData_nxt = rdata_r;
          hState_nxt = H_HOLD;
        end
      end
      H_HOLD: begin
        if (strbS_r[1]) begin
          hState_nxt = H_IDLE;
        end
      end
      default: hState_nxt = H_IDLE;
    endcase
  end

  // two-flop strobe sync
  // address and data are stable while the strobe is low, so the
  // synchronised copies settle before the synchronised strobe
  always_ff @(posedge hostClock or negedge rstn) begin
    if (!rstn) begin
      hState_r <= H_IDLE;
      strbS_r <= 2'h3;
      busS1_r <= 12'h000;
      busS2_r <= 12'h000;
      req_r <= '0;
      reqTog_r <= 1'b0;
      ackS_r <= 2'h0;
      hData_r <= 8'h00;
    end else if (clkEn) begin
      hState_r <= hState_nxt;
      strbS_r <= strbS_nxt;
      busS1_r <= busS1_nxt;
      busS2_r <= busS2_nxt;
      req_r <= req_nxt;
      reqTog_r <= reqTog_nxt;
      ackS_r <= ackS_nxt;
      hData_r <= hData_nxt;
    end
  end

  // ready idles low and only rises from a flop, so it cannot glitch
  // high while stalled
  assign ready = (hState_r == H_HOLD);
  assign dataOe = (hState_r == H_HOLD) && req_r.rd;
  assign dataOut = hData_r;

  // ==========================================================
  // core domain: register file, command, divider
  localparam int DIV_W_L = tmh_pkg::DIV_W;
  typedef enum logic {C_IDLE, C_SERVE} tmh_cstate_t;
  tmh_cstate_t cState_r, cState_nxt;
  logic [1:0] reqS_r, reqS_nxt;
  logic reqSeen_r, reqSeen_nxt;
  logic ackTog_nxt;
  logic [7:0] rdata_nxt;
  logic [1:0] scan_in_buffer_ready_flag_r, scan_in_buffer_ready_flag_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [2:0] disc_r, disc_nxt;
  logic discTck_r, discTck_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic cmdFull_r, cmdFull_nxt;
  logic [1:0] rstCnt_r, rstCnt_nxt;
  logic [DIV_W_L-1:0] divCnt_r, divCnt_nxt;
  logic phase_r, phase_nxt;
  logic tckRun_r, tckRun_nxt;
  logic take_r, take_nxt;
  logic stall, periodTick, pinDrive, freeRun;
  logic [DIV_W_L-1:0] divRatio;

  assign pinDrive = mode_r[tmh_pkg::MODE_PIN_DRIVE_BIT];
  assign freeRun = mode_r[tmh_pkg::MODE_FREE_RUN_BIT];
  assign divRatio = mode_r[tmh_pkg::MODE_DIV_LSB +: DIV_W_L];
  assign periodTick = (divCnt_r == divRatio) && phase_r;

  always_comb begin
    stall = 1'b0;
    if (!req_r.rd && req_r.addr == tmh_pkg::ADDR_CMD) begin
      stall = cmdFull_r || (rstCnt_r != 2'h0);
    end else if (req_r.rd && req_r.addr == tmh_pkg::ADDR_TDIBUF) begin
      stall = !scanInBufferReadyFlag;
    end
  end

  always_comb begin
    reqS_nxt = {reqS_r[0], reqTog_r};
    scan_in_buffer_ready_flag_nxt = {scan_in_buffer_ready_flag_r[0], tdi};
    cState_nxt = cState_r;
    reqSeen_nxt = reqSeen_r;
    ackTog_nxt = ackTog_r;
    rdata_nxt = rdata_r;
    mode_nxt = mode_r;
    disc_nxt = disc_r;
    discTck_nxt = discTck_r;
    cmd_nxt = cmd_r;
    cmdFull_nxt = cmdFull_r;
    rstCnt_nxt = rstCnt_r;
    take_nxt = 1'b0;
    divCnt_nxt = divCnt_r + 1'b1;
    phase_nxt = phase_r;
    tckRun_nxt = tckRun_r;
    if (divCnt_r == divRatio) begin
      divCnt_nxt = '0;
      phase_nxt = ~phase_r;
      if (phase_r) begin
        tckRun_nxt = freeRun || tckGate;
      end
    end
    if (periodTick && rstCnt_r != 2'h0) begin
      rstCnt_nxt = rstCnt_r - 2'h1;
    end
    if (cmdFull_r && cmdTake) begin
      cmdFull_nxt = 1'b0;
      rstCnt_nxt = tmh_pkg::CMD_RESET_TCKS;
    end
    case (cState_r)
      C_IDLE: begin
        if (reqS_r[1] != reqSeen_r) begin
          reqSeen_nxt = reqS_r[1];
          cState_nxt = C_SERVE;
        end
      end
      C_SERVE: begin
        if (!stall) begin
          ackTog_nxt = ~ackTog_r;
          cState_nxt = C_IDLE;
          if (req_r.rd) begin
            case (req_r.addr)
              tmh_pkg::ADDR_STATUS: begin
                rdata_nxt = 8'h00;
                rdata_nxt[tmh_pkg::STAT_CMD_FULL_BIT] = cmdFull_r;
                rdata_nxt[tmh_pkg::STAT_RST_BUSY_BIT] = rstCnt_r != 2'h0;
                rdata_nxt[tmh_pkg::STAT_TDI_READY_BIT] =
                  scanInBufferReadyFlag;
              end
              tmh_pkg::ADDR_MODE: rdata_nxt = mode_r;
              tmh_pkg::ADDR_DISC: begin
                rdata_nxt = {3'h0, discTck_r, scan_in_buffer_ready_flag_r[1], disc_r};
                if (pinDrive) begin
                  discTck_nxt = 1'b1;
                end
              end
              tmh_pkg::ADDR_TDIBUF: begin
                rdata_nxt = scanByte;
                take_nxt = 1'b1;
              end
              default: rdata_nxt = 8'h00;
            endcase
          end else begin
            case (req_r.addr)
              tmh_pkg::ADDR_CMD: begin
                cmd_nxt = req_r.wdata;
                cmdFull_nxt = 1'b1;
              end
              tmh_pkg::ADDR_MODE: mode_nxt = req_r.wdata;
              tmh_pkg::ADDR_DISC: begin
                disc_nxt = req_r.wdata[2:0];
                if (pinDrive) begin
                  discTck_nxt = 1'b0;
                end
              end
              default: rdata_nxt = rdata_r;
            endcase
          end
        end
      end
      default: cState_nxt = C_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cState_r <= C_IDLE;
      reqS_r <= 2'h0;
      reqSeen_r <= 1'b0;
      ackTog_r <= 1'b0;
      rdata_r <= 8'h00;
      scan_in_buffer_ready_flag_r <= 2'h0;
      mode_r <= tmh_pkg::MODE_RESET;
      disc_r <= tmh_pkg::DISC_RESET;
      discTck_r <= 1'b0;
      cmd_r <= 8'h00;
      cmdFull_r <= 1'b0;
      rstCnt_r <= 2'h0;
      divCnt_r <= '0;
      phase_r <= 1'b0;
      tckRun_r <= 1'b0;
      take_r <= 1'b0;
    end else if (clkEn) begin
      cState_r <= cState_nxt;
      reqS_r <= reqS_nxt;
      reqSeen_r <= reqSeen_nxt;
      ackTog_r <= ackTog_nxt;
      rdata_r <= rdata_nxt;
      scan_in_buffer_ready_flag_r <= scan_in_buffer_ready_flag_nxt;
      mode_r <= mode_nxt;
      disc_r <= disc_nxt;
      discTck_r <= discTck_nxt;
      cmd_r <= cmd_nxt;
      cmdFull_r <= cmdFull_nxt;
      rstCnt_r <= rstCnt_nxt;
      divCnt_r <= divCnt_nxt;
      phase_r <= phase_nxt;
      tckRun_r <= tckRun_nxt;
      take_r <= take_nxt;
    end
  end

  assign tms = pinDrive ? disc_r[tmh_pkg::DISC_TMS_BIT] : 1'b1;
  assign tdo = pinDrive ? disc_r[tmh_pkg::DISC_TDO_BIT] : 1'b1;
  assign trst = pinDrive ? disc_r[tmh_pkg::DISC_TRST_BIT] : 1'b1;
  assign tck = pinDrive ? discTck_r : (tckRun_r & phase_r);
  assign cmdWord = cmd_r;
  assign cmdValid = cmdFull_r;
  assign scanByteTake = take_r;

  // ==========================================================
  // assertions
  property p_rdy_hold;
    @(posedge hostClock) disable iff (!rstn)
    (ready && !strbS_r[1]) |=> ready;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold)
    else $error("ready dropped during strobe low");

  property p_rdy_low_wait;
    @(posedge hostClock) disable iff (!rstn)
    (hState_r == H_WAIT) |-> !ready;
  endproperty
  a_rdy_low_wait: assert property (p_rdy_low_wait)
    else $error("ready high while access pending");

  property p_rd_rise;
    @(posedge clock) disable iff (!rstn)
    (clkEn && cState_r == C_SERVE && !stall && req_r.rd &&
     req_r.addr == tmh_pkg::ADDR_DISC && pinDrive) |=> tck;
  endproperty
  a_rd_rise: assert property (p_rd_rise)
    else $error("pin-drive read did not raise tck");

  property p_wr_fall;
    @(posedge clock) disable iff (!rstn)
    (clkEn && cState_r == C_SERVE && !stall && !req_r.rd &&
     req_r.addr == tmh_pkg::ADDR_DISC && pinDrive) |=> !tck;
  endproperty
  a_wr_fall: assert property (p_wr_fall)
    else $error("pin-drive write did not lower tck");

  property p_other_steady;
    @(posedge clock) disable iff (!rstn)
    (cState_r == C_SERVE && req_r.addr != tmh_pkg::ADDR_DISC &&
     req_r.addr != tmh_pkg::ADDR_MODE && pinDrive) |=> $stable(tck);
  endproperty
  a_other_steady: assert property (p_other_steady)
    else $error("tck moved on another register access");

  property p_pins;
    @(posedge clock) disable iff (!rstn)
    pinDrive |-> (tms == disc_r[0] && tdo == disc_r[1] && trst == disc_r[2]);
  endproperty
  a_pins: assert property (p_pins)
    else $error("tap pins differ from pin-drive register");

  property p_cmd_stall;
    @(posedge clock) disable iff (!rstn)
    (cState_r == C_SERVE && !req_r.rd && req_r.addr == tmh_pkg::ADDR_CMD &&
     rstCnt_r != 2'h0) |=> (cState_r == C_SERVE && $stable(ackTog_r));
  endproperty
  a_cmd_stall: assert property (p_cmd_stall)
    else $error("command write taken during internal reset");

  property p_cmd_take;
    @(posedge clock) disable iff (!rstn)
    (clkEn && cState_r == C_SERVE && !req_r.rd &&
     req_r.addr == tmh_pkg::ADDR_CMD && !cmdFull_r && rstCnt_r == 2'h0)
    |=> (cmdValid && cmdWord == $past(req_r.wdata));
  endproperty
  a_cmd_take: assert property (p_cmd_take)
    else $error("command not accepted at once");

  property p_tdi_wait;
    @(posedge clock) disable iff (!rstn)
    (cState_r == C_SERVE && req_r.rd && req_r.addr == tmh_pkg::ADDR_TDIBUF &&
     !scanInBufferReadyFlag) |=> (cState_r == C_SERVE);
  endproperty
  a_tdi_wait: assert property (p_tdi_wait)
    else $error("empty scan-in read completed");

  property p_div;
    @(posedge clock) disable iff (!rstn)
    (clkEn && !pinDrive && $rose(phase_r) && divRatio == 4'h0)
    |=> (clkEn [*1] ##0 !phase_r);
  endproperty
  a_div: assert property (p_div)
    else $error("test clock half period wrong");

  c_disc_read: cover property (@(posedge clock)
    cState_r == C_SERVE && req_r.rd && req_r.addr == tmh_pkg::ADDR_DISC);
  c_cmd_stall: cover property (@(posedge clock)
    cState_r == C_SERVE && stall && req_r.addr == tmh_pkg::ADDR_CMD);
  c_tdi_stall: cover property (@(posedge clock)
    cState_r == C_SERVE && stall && req_r.addr == tmh_pkg::ADDR_TDIBUF);
  c_hold: cover property (@(posedge hostClock) hState_r == H_HOLD);
endmodule
`default_nettype wire

// File: sim/tmh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// host processor on the strobe/ready bus
module tmh_host_model (
  // host link clock
  input wire logic hostClock,
  // host bus pins
  output logic accessStrobeN,
  output logic hostRead,
  output logic [2:0] hostAddr,
  output logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic ready,
  // set if ready ever dropped inside one strobe after rising
  output logic readyGlitch
);
  logic readySeen;

  initial begin
    accessStrobeN = 1'b1;
    hostRead = 1'b1;
    hostAddr = 3'h0;
    dataIn = 8'h00;
    readyGlitch = 1'b0;
    readySeen = 1'b0;
  end

  always @(ready or accessStrobeN) begin
    if (accessStrobeN) begin
      readySeen = 1'b0;
    end else if (ready === 1'b1) begin
      readySeen = 1'b1;
    end else if (readySeen) begin
      readyGlitch = 1'b1;
    end
  end

  task automatic access(input logic r, input logic [2:0] a,
      input logic [7:0] w, output logic [7:0] rData, output logic oe,
      output logic done);
    int n;
    n = 0;
    @(posedge hostClock);
    accessStrobeN <= 1'b0;
    hostRead <= r;
    hostAddr <= a;
    dataIn <= w;
    // ready only sampled on link clock edges
    do begin
      @(posedge hostClock);
      n++;
    end while (ready !== 1'b1 && n < 400);
    done = (ready === 1'b1);
    rData = dataOut;
    oe = dataOe;
    accessStrobeN <= 1'b1;
    hostRead <= ~r;
    hostAddr <= ~a;
    // released bus shows the inverse, not a stale copy
    dataIn <= ~w;
    repeat (4) @(posedge hostClock);
  endtask
endmodule
`default_nettype wire

// File: sim/tap_master_host_handshake_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tap_master_host_handshake_bench;
  logic clock, hostClock, rstn, cmdTake, scanFlag, tckGate, tdi;
  logic accessStrobeN, hostRead, dataOe, ready, cmdValid, scanByteTake;
  logic tck, tms, tdo, trst, readyGlitch, lastOe, accDone, clkEn;
  logic [2:0] hostAddr;
  logic [7:0] dataIn, dataOut, cmdWord, scanByte, rd;
  int numErrors, cmpCount, takeCount;

  tmh_host_port dut_u (.clock(clock), .rstn(rstn), .clkEn(clkEn),
    .hostClock(hostClock), .accessStrobeN(accessStrobeN),
    .hostRead(hostRead), .hostAddr(hostAddr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .ready(ready),
    .cmdWord(cmdWord), .cmdValid(cmdValid), .cmdTake(cmdTake),
    .scanByte(scanByte), .scanInBufferReadyFlag(scanFlag),
    .scanByteTake(scanByteTake), .tckGate(tckGate), .tdi(tdi),
    .tck(tck), .tms(tms), .tdo(tdo), .trst(trst));

  tmh_host_model host_u (.hostClock(hostClock),
    .accessStrobeN(accessStrobeN), .hostRead(hostRead),
    .hostAddr(hostAddr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .ready(ready), .readyGlitch(readyGlitch));

  always #50 clock = ~clock;
  // link clock period 125 ns, no phase relation to the core clock
  always #62.5 hostClock = ~hostClock;

  // engine consumes a scan byte on its take pulse
  always @(posedge clock) begin
    if (scanByteTake === 1'b1) begin
      scanFlag <= 1'b0;
      takeCount++;
    end
  end

  // ====================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] w);
    host_u.access(r, a, w, rd, lastOe, accDone);
    check(accDone, 1'b1);
  endtask

  task automatic wrapUp();
    if (numErrors == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ====================================================
  // scenarios
  task automatic testPinDrive();
    check({tms, tdo, trst, tck, ready}, 5'h1C);
    @(posedge clock) tdi <= 1'b1;
    acc(1'b0, tmh_pkg::ADDR_MODE, 8'h01);
    acc(1'b1, tmh_pkg::ADDR_MODE, 8'h00);
    check({lastOe, rd, tck}, 10'h202);
    acc(1'b0, tmh_pkg::ADDR_DISC, 8'h05);
    check({tms, tdo, trst, tck}, 4'hA);
    acc(1'b1, tmh_pkg::ADDR_DISC, 8'h00);
    check({tck, rd[3:0]}, 5'h1D);
    acc(1'b1, tmh_pkg::ADDR_STATUS, 8'h00);
    check(tck, 1'b1);
    acc(1'b0, tmh_pkg::ADDR_MODE, 8'h01);
    check(tck, 1'b1);
    acc(1'b0, tmh_pkg::ADDR_DISC, 8'h02);
    check({tms, tdo, trst, tck}, 4'h4);
    acc(1'b0, tmh_pkg::ADDR_MODE, 8'h30);
    check({tms, tdo, trst}, 3'h7);
  endtask

  task automatic testCommand();
    int lowCount;
    lowCount = 0;
    acc(1'b0, tmh_pkg::ADDR_CMD, 8'h11);
    check({cmdValid, cmdWord}, 9'h111);
    fork
      acc(1'b0, tmh_pkg::ADDR_CMD, 8'h22);
      begin
        repeat (20) @(posedge clock);
        check({ready, cmdWord}, 9'h011);
        cmdTake <= 1'b1;
        @(posedge clock) cmdTake <= 1'b0;
        // ratio 3: 8 core clocks a test-clock period; the divider phase
        // is free, so only two whole periods of the three are certain
        repeat (16) begin
          @(posedge clock);
          if (ready === 1'b0 && cmdValid === 1'b0) lowCount++;
        end
        check(lowCount, 16);
      end
    join
    check({cmdValid, cmdWord}, 9'h122);
    @(posedge clock) cmdTake <= 1'b1;
    @(posedge clock) cmdTake <= 1'b0;
    repeat (26) @(posedge clock);
    acc(1'b0, tmh_pkg::ADDR_CMD, 8'h33);
    check({cmdValid, cmdWord}, 9'h133);
    @(posedge clock) cmdTake <= 1'b1;
    @(posedge clock) cmdTake <= 1'b0;
  endtask

  task automatic tckPeriod(input logic [3:0] ratio, input logic free);
    realtime t1;
    acc(1'b0, tmh_pkg::ADDR_MODE, {ratio, 2'b00, free, 1'b0});
    @(posedge clock) tckGate <= ~free;
    // first period after a mode change may be short
    repeat (2) @(posedge tck);
    t1 = $realtime;
    @(posedge tck);
    check(int'(($realtime - t1) / 100.0), 2 * (ratio + 1));
  endtask

  task automatic testTck();
    logic held;
    int moved;
    moved = 0;
    tckPeriod(4'h2, 1'b1);
    // clock enable low freezes the free-running divider
    @(posedge clock) clkEn <= 1'b0;
    @(posedge clock) held = tck;
    repeat (20) begin
      @(posedge clock);
      if (tck !== held) moved++;
    end
    check(moved, 0);
    @(posedge clock) clkEn <= 1'b1;
    tckPeriod(4'h5, 1'b0);
    @(posedge clock) tckGate <= 1'b0;
    repeat (20) @(posedge clock);
    held = tck;
    repeat (40) @(posedge clock);
    check({held, tck}, 2'h0);
  endtask

  task automatic testScanRead();
    fork
      acc(1'b1, tmh_pkg::ADDR_TDIBUF, 8'h00);
      begin
        repeat (30) @(posedge clock);
        check(ready, 1'b0);
        scanByte <= 8'h3C;
        scanFlag <= 1'b1;
      end
    join
    check({lastOe, rd}, 9'h13C);
    repeat (5) @(posedge clock);
    check(takeCount, 1);
    acc(1'b0, 3'h7, 8'h5A);
    acc(1'b1, 3'h7, 8'h00);
    check({lastOe, rd}, 9'h100);
    check(readyGlitch, 1'b0);
  endtask

  initial begin
    clock = 1'b0;
    hostClock = 1'b0;
    rstn = 1'b0;
    cmdTake = 1'b0;
    scanFlag = 1'b0;
    tckGate = 1'b0;
    tdi = 1'b0;
    clkEn = 1'b1;
    scanByte = 8'h00;
    numErrors = 0;
    cmpCount = 0;
    takeCount = 0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    testPinDrive();
    testCommand();
    testTck();
    testScanRead();
    wrapUp();
  end

  // 16 accesses of a few microseconds each fit well inside this
  initial begin
    #500000;
    numErrors++;
    wrapUp();
  end
endmodule
`default_nettype wire
